//--- adc_far_side.sv
// Behavioural converter on the analog-input side of the control registers.
// Assumes adc_req pulses from motion_regs and the single board clock.
`timescale 1ns/1ps
module adc_far_side (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire motion_regs_pkg::adc_req_t adc_req,
    output logic                          conversion_valid,
    output logic [13:0]                   conversion_data
);
    import motion_regs_pkg::*;

    logic [3:0] cmd;
    logic [2:0] left;
    logic [2:0] idx;
    logic [3:0] gap;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cmd              <= 4'h0;
            left             <= 3'h0;
            idx              <= 3'h0;
            gap              <= 4'h0;
            conversion_valid <= 1'b0;
            conversion_data  <= 14'h0000;
        end else begin
            conversion_valid <= 1'b0;
            // Stale data is inverted every cycle, so a sample one cycle late cannot pass
            conversion_data  <= ~conversion_data;
            if (adc_req.cmd_load)
                cmd <= adc_req.cmd;
            if (adc_req.start && cmd != 4'h8) begin
                left <= {1'b0, cmd[1:0]} + 3'h1;
                idx  <= 3'h0;
                gap  <= 4'h5;
            end else if (left != 3'h0) begin
                if (gap != 4'h0) begin
                    gap <= gap - 4'h1;
                end else begin
                    conversion_valid <= 1'b1;
                    conversion_data  <= 14'h2a00 | {6'h00, cmd, 1'b0, idx};
                    left             <= left - 3'h1;
                    idx              <= idx + 3'h1;
                    gap              <= 4'h2;
                end
            end
        end
    end
endmodule : adc_far_side

//--- motion_regs.sv
// Auxiliary I/O, variant word, interval timer, supervision timer,
// analog-output strobes and analog-input sequencing of the motion board.
// Assumes one-cycle bus strobes synchronous to clk_sys and a converter
// that returns one result per conversion_valid pulse.
`timescale 1ns/1ps
`include "motion_regs_map.svh"

// What this block does
// - Offset 24 drives and reads outputs 16-19
// - Offset 24 bits 16-21 read inputs 32-37
// - Bit 22 watchdog state, bit 23 jumper
// - Offset 28 returns read-only variant word
// - Timer compare keeps only bits 0-7
// - One timer count per 15.5 us
// - Writing one at 68 clears, disables timer
// - Writing one at 72 arms one-shot upcount
// - Reaching compare raises timer interrupt
// - Control bit 0 picks 8 or 16 ms
// - Control bit 2 enables watchdog; 1,3 reserved
// - Bit 4 lets analog writes kick watchdog
// - Writing 0x5a at 80 kicks watchdog
// - Timeout resets board, drives watchdog low
// - Eight analog-output words at 96-124, 13 bits
// - Analog codes offset binary, 0x1000 is zero
// - Read 128 returns next 14-bit result
// - Writing one at 160 starts conversions
// - Codes 0-7 pick channels, 8 powers down
// - Done flag low when finished, first read high
module motion_regs #(
    parameter int WD_SHORT_CYC = `WD_SHORT_MS * `WD_CYC_PER_MS,
    parameter int WD_LONG_CYC  = `WD_LONG_MS * `WD_CYC_PER_MS
) (
    input  wire logic                     clk_sys,
    input  wire logic                     rst_b,
    input  wire motion_regs_pkg::bus_req_t bus_req,
    output logic [31:0]                   bus_rdata,
    output logic                          bus_rvalid,
    output logic [3:0]                    aux_out,
    input  wire logic [5:0]               aux_in,
    input  wire logic                     option_jumper_b,
    output logic                          timer_irq,
    output logic                          supervision_timer_out_b,
    output logic                          board_reset,
    output motion_regs_pkg::dac_out_t     dac,
    output motion_regs_pkg::adc_req_t     adc_req,
    input  wire logic                     conversion_valid,
    input  wire logic [13:0]              conversion_data,
    output logic                          conversion_finished_b
);
    import motion_regs_pkg::*;

    localparam int TICK_CYC = `TMR_TICK_CYC;

    function automatic logic hit(input logic [8:0] a,
                                 input logic [8:0] off);
        return a[8:2] == off[8:2];
    endfunction : hit

    logic        wr;
    logic        rd;
    logic        dac_hit;
    logic        wd_fire;
    logic        wd_kick;
    logic [7:0]  tmr_cmp;
    logic [7:0]  tmr_cnt;
    logic [8:0]  tmr_pre;
    logic        tmr_run;
    logic        tmr_tick;
    logic        tmr_hit;
    logic        arm_wr;
    logic        clr_wr;
    logic        wd_en;
    logic        wd_tb;
    logic        wd_dack;
    logic [18:0] wd_cnt;
    logic [18:0] wd_limit;
    adc_state_t  adc_state;
    logic [3:0]  adc_cmd;
    logic [13:0] adc_res [4];
    logic [2:0]  adc_got;
    logic [2:0]  adc_rd;
    logic [2:0]  adc_n;
    logic        adc_go;
    logic        adc_pop;

    assign wr      = bus_req.wr;
    assign rd      = bus_req.rd;
    // Analog-output words occupy 0x60..0x7c
    assign dac_hit = bus_req.addr[8:5] == 4'(`OFF_DAC_BASE >> 5);
    assign arm_wr  = wr && hit(bus_req.addr, `OFF_TMR_ARM)
                     && bus_req.wdata[0];
    assign clr_wr  = wr && hit(bus_req.addr, `OFF_TMR_CLR)
                     && bus_req.wdata[0];

    // Auxiliary outputs
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            aux_out <= `RST_AUX_OUT;
        end else if (wd_fire) begin
            aux_out <= `RST_AUX_OUT;
        end else if (wr && hit(bus_req.addr, `OFF_AUX_IO)) begin
            aux_out <= bus_req.wdata[`AUX_OUT_LSB +: 4];
        end
    end

    // Interval timer: prescaler makes the count tick
    assign tmr_tick = tmr_run && tmr_pre == 9'(TICK_CYC - 1);
    // A zero compare fires on the first tick rather than wrapping
    assign tmr_hit  = tmr_tick
                      && {1'b0, tmr_cnt} + 9'd1 >= {1'b0, tmr_cmp};

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tmr_cmp <= 8'h00;
        end else if (wr && hit(bus_req.addr, `OFF_TMR_CMP)) begin
            tmr_cmp <= bus_req.wdata[7:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tmr_pre <= 9'h000;
        end else if (!tmr_run || arm_wr || tmr_tick) begin
            tmr_pre <= 9'h000;
        end else begin
            tmr_pre <= tmr_pre + 9'd1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tmr_run <= 1'b0;
            tmr_cnt <= 8'h00;
        end else if (clr_wr || wd_fire) begin
            tmr_run <= 1'b0;
        end else if (arm_wr) begin
            tmr_run <= 1'b1;
            tmr_cnt <= 8'h00;
        end else if (tmr_hit) begin
            tmr_run <= 1'b0;
        end else if (tmr_tick) begin
            tmr_cnt <= tmr_cnt + 8'd1;
        end
    end

    // A hit in the clearing cycle still raises the request
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            timer_irq <= 1'b0;
        end else if (tmr_hit) begin
            timer_irq <= 1'b1;
        end else if (clr_wr || wd_fire) begin
            timer_irq <= 1'b0;
        end
    end

    // Supervision timer
    assign wd_limit = wd_tb ? 19'(WD_LONG_CYC) : 19'(WD_SHORT_CYC);
    assign wd_kick  = (wr && hit(bus_req.addr, `OFF_WD_KICK)
                       && bus_req.wdata[7:0] == `WD_KICK_CODE)
                      || (wr && dac_hit && wd_dack);
    // A kick in the last counted cycle still arrives in time
    assign wd_fire  = wd_en && !wd_kick && wd_cnt == wd_limit - 19'd1;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wd_en   <= 1'b0;
            wd_tb   <= 1'b0;
            wd_dack <= 1'b0;
        end else if (wd_fire) begin
            wd_en   <= 1'b0;
        end else if (wr && hit(bus_req.addr, `OFF_WD_CTRL)) begin
            wd_tb   <= bus_req.wdata[`WD_TB_BIT];
            wd_en   <= bus_req.wdata[`WD_EN_BIT];
            wd_dack <= bus_req.wdata[`WD_DACK_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            wd_cnt <= 19'h00000;
        end else if (!wd_en || wd_kick) begin
            wd_cnt <= 19'h00000;
        end else begin
            wd_cnt <= wd_cnt + 19'd1;
        end
    end

    // Trip stays visible until the next kick so software can see it
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            supervision_timer_out_b <= 1'b1;
            board_reset             <= 1'b0;
        end else begin
            board_reset <= wd_fire;
            if (wd_fire) begin
                supervision_timer_out_b <= 1'b0;
            end else if (wd_kick) begin
                supervision_timer_out_b <= 1'b1;
            end
        end
    end

    // Analog outputs: code passed as written, offset binary
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            dac.load <= 1'b0;
            dac.chan <= 3'h0;
            dac.code <= `DAC_MID;
        end else begin
            dac.load <= wr && dac_hit;
            if (wr && dac_hit) begin
                dac.chan <= bus_req.addr[4:2];
                dac.code <= bus_req.wdata[12:0];
            end
        end
    end

    // Analog-input sequencing
    assign adc_n   = {1'b0, adc_cmd[1:0]} + 3'd1;
    assign adc_go  = wr && hit(bus_req.addr, `OFF_ADC_GO)
                     && bus_req.wdata[0] && adc_state != ADC_BUSY
                     && adc_cmd != `ADC_PWRDN;
    assign adc_pop = rd && hit(bus_req.addr, `OFF_ADC_DATA)
                     && adc_state == ADC_READY;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adc_cmd <= `RST_ADC_CMD;
        end else if (wr && hit(bus_req.addr, `OFF_ADC_DATA)
                     && adc_state != ADC_BUSY) begin
            adc_cmd <= bus_req.wdata[3:0];
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adc_req.cmd_load <= 1'b0;
            adc_req.start    <= 1'b0;
            adc_req.cmd      <= `RST_ADC_CMD;
        end else begin
            adc_req.cmd_load <= wr && hit(bus_req.addr, `OFF_ADC_DATA)
                                && adc_state != ADC_BUSY;
            adc_req.start    <= adc_go;
            // Mirror the stored command; busy-time writes are dropped
            if (wr && hit(bus_req.addr, `OFF_ADC_DATA)
                && adc_state != ADC_BUSY) begin
                adc_req.cmd <= bus_req.wdata[3:0];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (adc_state == ADC_BUSY && conversion_valid) begin
            adc_res[adc_got[1:0]] <= conversion_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            adc_state             <= ADC_IDLE;
            adc_got               <= 3'h0;
            adc_rd                <= 3'h0;
            conversion_finished_b <= 1'b1;
        end else if (wd_fire) begin
            adc_state             <= ADC_IDLE;
            conversion_finished_b <= 1'b1;
        end else begin
            case (adc_state)
                ADC_IDLE, ADC_READY: begin
                    if (adc_go) begin
                        adc_state             <= ADC_BUSY;
                        adc_got               <= 3'h0;
                        adc_rd                <= 3'h0;
                        conversion_finished_b <= 1'b1;
                    end else if (adc_pop) begin
                        conversion_finished_b <= 1'b1;
                        adc_rd <= adc_rd + 3'd1;
                        if (adc_rd + 3'd1 == adc_n) begin
                            adc_state <= ADC_IDLE;
                        end
                    end
                end
                ADC_BUSY: begin
                    if (conversion_valid) begin
                        adc_got <= adc_got + 3'd1;
                        if (adc_got + 3'd1 == adc_n) begin
                            adc_state             <= ADC_READY;
                            conversion_finished_b <= 1'b0;
                        end
                    end
                end
                default: begin
                    adc_state <= ADC_IDLE;
                end
            endcase
        end
    end

    // Read answers; unmapped words and reserved bits give zero
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus_rdata  <= 32'h0000_0000;
            bus_rvalid <= 1'b0;
        end else begin
            bus_rvalid <= rd;
            if (rd) begin
                bus_rdata <= 32'h0000_0000;
                if (hit(bus_req.addr, `OFF_AUX_IO)) begin
                    bus_rdata[`AUX_OUT_LSB +: 4] <= aux_out;
                    bus_rdata[`AUX_IN_LSB +: 6]  <= aux_in;
                    bus_rdata[`AUX_WD_BIT] <= supervision_timer_out_b;
                    bus_rdata[`AUX_JMP_BIT] <= option_jumper_b;
                end else if (hit(bus_req.addr, `OFF_VARIANT)) begin
                    bus_rdata <= `VARIANT_ID;
                end else if (adc_pop) begin
                    bus_rdata[13:0] <= adc_res[adc_rd[1:0]];
                end
            end
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    sequence armed_one;
        arm_wr && tmr_cmp == 8'd1 && !clr_wr && !wd_fire;
    endsequence

    sequence last_result;
        adc_state == ADC_BUSY && conversion_valid
            && adc_got + 3'd1 == adc_n && !wd_fire;
    endsequence

    AST_AUX_WRITE: assert property (
        wr && hit(bus_req.addr, `OFF_AUX_IO) && !wd_fire
        |=> aux_out == $past(bus_req.wdata[3:0]))
        else $error("aux outputs not written");
    AST_AUX_READ: assert property (
        rd && hit(bus_req.addr, `OFF_AUX_IO)
        |=> bus_rvalid && bus_rdata[21:16] == $past(aux_in)
            && bus_rdata[23] == $past(option_jumper_b))
        else $error("aux read word wrong");
    AST_VARIANT: assert property (
        rd && hit(bus_req.addr, `OFF_VARIANT)
        |=> bus_rdata == `VARIANT_ID)
        else $error("variant word wrong");
    AST_TMR_TICK: assert property (
        armed_one |-> ##[TICK_CYC:TICK_CYC] (tmr_hit || !tmr_run))
        else $error("timer tick period wrong");
    AST_TMR_CLR: assert property (
        clr_wr && !tmr_hit |=> !timer_irq && !tmr_run)
        else $error("timer clear failed");
    AST_TMR_IRQ: assert property (
        tmr_hit && !arm_wr |=> timer_irq && !tmr_run)
        else $error("timer interrupt missing");
    AST_WD_KICK: assert property (
        wd_en && wr && hit(bus_req.addr, `OFF_WD_KICK)
        && bus_req.wdata[7:0] == `WD_KICK_CODE
        && !(wr && hit(bus_req.addr, `OFF_WD_CTRL))
        |=> wd_cnt == 19'h0 && supervision_timer_out_b)
        else $error("watchdog kick ignored");
    AST_WD_DAC: assert property (
        wd_en && wd_dack && wr && dac_hit && !wd_fire
        |=> wd_cnt == 19'h0)
        else $error("analog write did not kick");
    AST_WD_TRIP: assert property (
        wd_fire && !tmr_hit |=> !supervision_timer_out_b && board_reset
            && aux_out == 4'h0 && !timer_irq ##1 !board_reset)
        else $error("watchdog timeout effects wrong");
    AST_DAC_LOAD: assert property (
        wr && dac_hit |=> dac.load
            && dac.code == $past(bus_req.wdata[12:0]))
        else $error("analog output strobe wrong");
    AST_ADC_START: assert property (
        adc_go && !wd_fire |=> adc_req.start && adc_state == ADC_BUSY)
        else $error("conversion start missing");
    AST_ADC_DONE: assert property (
        last_result |=> !conversion_finished_b
            && adc_state == ADC_READY)
        else $error("done flag not lowered");
    AST_ADC_FIRST_READ: assert property (
        adc_pop && !adc_go && !wd_fire |=> conversion_finished_b)
        else $error("first read did not raise done flag");
endmodule : motion_regs

//--- motion_regs_map.svh
// Offsets, field positions, reset values and timing figures of the
// motion board control registers.
// Assumes a 25 MHz board clock and byte addresses within a 512-byte window.
`ifndef MOTION_REGS_MAP_SVH
`define MOTION_REGS_MAP_SVH
`define OFF_AUX_IO      9'h018
`define OFF_VARIANT     9'h01c
`define OFF_TMR_CMP     9'h040
`define OFF_TMR_CLR     9'h044
`define OFF_TMR_ARM     9'h048
`define OFF_WD_CTRL     9'h04c
`define OFF_WD_KICK     9'h050
`define OFF_DAC_BASE    9'h060
`define OFF_ADC_DATA    9'h080
`define OFF_ADC_GO      9'h0a0
`define AUX_OUT_LSB     0
`define AUX_IN_LSB      16
`define AUX_WD_BIT      22
`define AUX_JMP_BIT     23
`define WD_TB_BIT       0
`define WD_EN_BIT       2
`define WD_DACK_BIT     4
`define WD_KICK_CODE    8'h5a
`define DAC_MID         13'h1000
`define ADC_PWRDN       4'h8
`define RST_ADC_CMD     4'h0
`define RST_AUX_OUT     4'h0
`define VARIANT_ID      32'h0000_00a5 // Arbitrary value, no real part
`define CLK_MHZ         25
`define TMR_TICK_NS     15500
`define TMR_TICK_CYC    ((`TMR_TICK_NS * `CLK_MHZ + 999) / 1000)
`define WD_SHORT_MS     8
`define WD_LONG_MS      16
`define WD_CYC_PER_MS   (`CLK_MHZ * 1000)
`endif

//--- motion_regs_pkg.sv
// Types shared by the motion board control registers and their users.
// Assumes the constants of motion_regs_map.svh.
package motion_regs_pkg;
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [8:0]  addr;
        logic [31:0] wdata;
    } bus_req_t;

    typedef struct packed {
        logic        load;
        logic [2:0]  chan;
        logic [12:0] code;
    } dac_out_t;

    typedef struct packed {
        logic       cmd_load;
        logic       start;
        logic [3:0] cmd;
    } adc_req_t;

    typedef enum logic [1:0] {
        ADC_IDLE  = 2'b00,
        ADC_BUSY  = 2'b01,
        ADC_READY = 2'b10
    } adc_state_t;
endpackage : motion_regs_pkg

//--- test_motion_board_control_registers.sv
// Self-checking bench for the motion board control registers.
// Assumes shortened supervision spans and the adc_far_side converter model.
`timescale 1ns/1ps
`include "motion_regs_map.svh"
module test_motion_board_control_registers;
    import motion_regs_pkg::*;
    // Short spans keep the run brief; expectations derive from them
    localparam int SHORT_CYC = 40;
    localparam int LONG_CYC  = 80;

    logic        clk_sys = 1'b0;
    logic        rst_b = 1'b0;
    bus_req_t    bus_req = '0;
    logic [31:0] bus_rdata;
    logic        bus_rvalid;
    logic [3:0]  aux_out;
    logic [5:0]  aux_in = 6'h2d;
    logic        option_jumper_b = 1'b0;
    logic        timer_irq;
    logic        supervision_timer_out_b;
    logic        board_reset;
    dac_out_t    dac;
    adc_req_t    adc_req;
    logic        conversion_valid;
    logic [13:0] conversion_data;
    logic        conversion_finished_b;
    int          err_total = 0;
    int          tests_run = 0;
    int          resets_seen = 0;
    logic [31:0] rd;

    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (board_reset === 1'b1) resets_seen++;

    motion_regs #(.WD_SHORT_CYC(SHORT_CYC), .WD_LONG_CYC(LONG_CYC)) i_dut (
        .clk_sys(clk_sys), .rst_b(rst_b), .bus_req(bus_req),
        .bus_rdata(bus_rdata), .bus_rvalid(bus_rvalid), .aux_out(aux_out),
        .aux_in(aux_in), .option_jumper_b(option_jumper_b),
        .timer_irq(timer_irq),
        .supervision_timer_out_b(supervision_timer_out_b),
        .board_reset(board_reset), .dac(dac), .adc_req(adc_req),
        .conversion_valid(conversion_valid),
        .conversion_data(conversion_data),
        .conversion_finished_b(conversion_finished_b));

    adc_far_side i_far (
        .clk_sys(clk_sys), .rst_b(rst_b), .adc_req(adc_req),
        .conversion_valid(conversion_valid),
        .conversion_data(conversion_data));

    task automatic stop_test;
        $display("Checks run %0d, mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wait_cyc

    task automatic bus_wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= {1'b1, 1'b0, a, d};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
    endtask : bus_wr

    task automatic bus_rd(input logic [8:0] a, output logic [31:0] d);
        @(posedge clk_sys);
        bus_req <= {1'b0, 1'b1, a, 32'h0};
        @(posedge clk_sys);
        bus_req <= '0;
        #1;
        check({31'h0, bus_rvalid}, 32'h1);
        d = bus_rdata;
    endtask : bus_rd

    task automatic t_reset;
        check({31'h0, supervision_timer_out_b}, 32'h1);
        check({19'h0, dac.code}, {19'h0, `DAC_MID});
        check({31'h0, conversion_finished_b}, 32'h1);
        check({31'h0, timer_irq}, 32'h0);
    endtask : t_reset

    task automatic t_aux_id;
        bus_wr(`OFF_AUX_IO, 32'hffff_fff5);
        check({28'h0, aux_out}, 32'h5);
        bus_rd(`OFF_AUX_IO, rd);
        check(rd, {8'h00, 1'b0, 1'b1, 6'h2d, 12'h000, 4'h5});
        @(posedge clk_sys);
        option_jumper_b <= 1'b1;
        aux_in <= 6'h12;
        bus_rd(`OFF_AUX_IO, rd);
        check(rd, {8'h00, 1'b1, 1'b1, 6'h12, 12'h000, 4'h5});
        bus_wr(`OFF_VARIANT, 32'h0);
        bus_rd(`OFF_VARIANT, rd);
        check(rd, `VARIANT_ID);
        bus_rd(9'h030, rd);
        check(rd, 32'h0);
        bus_rd(`OFF_TMR_CMP, rd);
        check(rd, 32'h0);
    endtask : t_aux_id

    task automatic t_dac;
        for (int i = 0; i < 8; i++) begin
            bus_wr(`OFF_DAC_BASE + 9'(4 * i), 32'hffff_e000 | (32'h111 * i));
            check({28'h0, dac.load, dac.chan}, {28'h0, 1'b1, 3'(i)});
            check({19'h0, dac.code}, {19'h0, 13'(32'h111 * i)});
        end
    endtask : t_dac

    task automatic t_timer;
        // Upper bits set on purpose: only the low byte may count
        bus_wr(`OFF_TMR_CMP, 32'hffff_ff02);
        for (int r = 0; r < 2; r++) begin
            bus_wr(`OFF_TMR_ARM, 32'h1);
            wait_cyc(2 * `TMR_TICK_CYC - 1);
            check({31'h0, timer_irq}, 32'h0);
            wait_cyc(3);
            check({31'h0, timer_irq}, 32'h1);
            wait_cyc(10);
            check({31'h0, timer_irq}, 32'h1);
            bus_wr(`OFF_TMR_CLR, 32'h1);
            check({31'h0, timer_irq}, 32'h0);
        end
        // A compare of one must fire after exactly one tick
        bus_wr(`OFF_TMR_CMP, 32'h0000_0001);
        bus_wr(`OFF_TMR_ARM, 32'h1);
        wait_cyc(`TMR_TICK_CYC - 1);
        check({31'h0, timer_irq}, 32'h0);
        wait_cyc(1);
        check({31'h0, timer_irq}, 32'h1);
        bus_wr(`OFF_TMR_CLR, 32'h1);
        check({31'h0, timer_irq}, 32'h0);
        wait_cyc(3 * `TMR_TICK_CYC);
        check({31'h0, timer_irq}, 32'h0);
    endtask : t_timer

    task automatic t_adc;
        int n;
        for (int c = 0; c < 9; c++) begin
            bus_wr(`OFF_ADC_DATA, 32'(c));
            check({27'h0, adc_req.cmd_load, adc_req.cmd},
                  {27'h0, 1'b1, 4'(c)});
            bus_wr(`OFF_ADC_GO, 32'h1);
            check({31'h0, adc_req.start}, {31'h0, c != 8});
            if (c < 8) begin
                n = (c % 4) + 1;
                for (int w = 0; w < 40 && conversion_finished_b !== 1'b0; w++)
                    wait_cyc(1);
                check({31'h0, conversion_finished_b}, 32'h0);
                for (int k = 0; k < n; k++) begin
                    bus_rd(`OFF_ADC_DATA, rd);
                    check(rd, 32'(32'h2a00 | (c << 4) | k));
                    check({31'h0, conversion_finished_b}, 32'h1);
                end
            end
        end
    endtask : t_adc

    task automatic t_supervision;
        int base;
        base = resets_seen;
        bus_wr(`OFF_WD_CTRL, 32'h0000_0004);
        wait_cyc(SHORT_CYC - 10);
        bus_wr(`OFF_WD_KICK, 32'h0000_005a);
        wait_cyc(SHORT_CYC - 10);
        check({31'h0, supervision_timer_out_b}, 32'h1);
        wait_cyc(15);
        check({31'h0, supervision_timer_out_b}, 32'h0);
        check({28'h0, aux_out}, 32'h0);
        check(32'(resets_seen - base), 32'h1);
        bus_wr(`OFF_WD_KICK, 32'h0000_005a);
        check({31'h0, supervision_timer_out_b}, 32'h1);
        bus_wr(`OFF_WD_CTRL, 32'h0000_0005);
        wait_cyc(SHORT_CYC + 10);
        check({31'h0, supervision_timer_out_b}, 32'h1);
        wait_cyc(LONG_CYC - SHORT_CYC);
        check({31'h0, supervision_timer_out_b}, 32'h0);
        bus_wr(`OFF_WD_KICK, 32'h0000_005a);
        bus_wr(`OFF_WD_CTRL, 32'h0000_0014);
        repeat (4) begin
            wait_cyc(SHORT_CYC - 10);
            bus_wr(`OFF_DAC_BASE, 32'h0000_1000);
        end
        check({31'h0, supervision_timer_out_b}, 32'h1);
        bus_wr(`OFF_WD_KICK, 32'h0000_005a);
        bus_wr(`OFF_WD_CTRL, 32'h0000_0004);
        wait_cyc(SHORT_CYC - 10);
        bus_wr(`OFF_DAC_BASE, 32'h0000_1000);
        wait_cyc(15);
        check({31'h0, supervision_timer_out_b}, 32'h0);
        bus_wr(`OFF_WD_KICK, 32'h0000_005a);
        bus_wr(`OFF_WD_CTRL, 32'h0000_0000);
        wait_cyc(2 * LONG_CYC);
        check({31'h0, supervision_timer_out_b}, 32'h1);
    endtask : t_supervision

    initial begin
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        wait_cyc(1);
        t_reset;
        t_aux_id;
        t_dac;
        t_timer;
        t_adc;
        t_supervision;
        stop_test;
    end

    // Whole run needs well under 6000 cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        stop_test;
    end
endmodule : test_motion_board_control_registers
